// ### verilog/prs_sequencer.sv
// Readout sequencer: registers, row pointers and column pair addressing
`include "prs_map.svh"
// Notes on behaviour
// RULE_01: Sub-sample code gives step 2,4,6,8 or 12.
// RULE_02: Always read two adjacent pixels per step.
// RULE_03: Blocks 24 wide; 99 column, 138 row starts. Code spaces column starts 12 columns apart.
// RULE_04: Columns addressed in pairs, rows singly.
// RULE_05: Read and reset pointers share row clock.
// RULE_06: Bit 4 or keep-charge mode drives both sides.
// RULE_07: Controller supplies 40 MHz pixel clock.
// RULE_08: Frame start restarts row addressing.
// RULE_09: Row clock selects row, starts blanking.
// RULE_10: Pulse timing follows loaded register bits.
// RULE_11: Bit 0 selects double-sample or keep-charge.
// RULE_12: Variant field ignored when bit 0 clear.
// RULE_13: Bit 3 resets pixels before readout.
// RULE_14: Bit 7 applies continuous precharge.
// RULE_15: Bits 9:8 set column clock granularity.
// RULE_16: Bit 10 disconnects column amplifiers.
// RULE_17: Bit 11 holds all pixels in reset.
// RULE_18: Sequencer register resets to 0x100.
// RULE_19: Pixel count register, max 1111 pairs.
// RULE_20: Keep-charge mode resets once, reads many.
// RULE_21: Reset spacing sets short slope integration.
// RULE_22: Variant codes: reset1, read1, reset2, read2.
// RULE_23: Core bits 4:2 column, 7:5 row sub-sample.
// RULE_24: Controller changes settings only between frames.
module prs_sequencer
  import prs_pkg::*;
#(
  parameter int ROW_W = 12,
  parameter int BLANK_CYC = 288
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [`PRS_ADDR_W-1:0] reg_addr,
  input wire logic [11:0] reg_wdata,
  output logic [11:0] reg_rdata,
  input wire logic frame_start,
  input wire logic row_clock,
  output logic [ROW_W-1:0] read_row,
  output logic [ROW_W-1:0] reset_row,
  output logic read_row_sel,
  output logic reset_row_sel,
  output logic both_side_drive,
  output logic [11:0] col_even,
  output logic [11:0] col_odd,
  output logic col_pair_valid,
  output logic col_clock_en,
  output logic blanking,
  output logic double_sample,
  output logic keep_charge_reset_frame,
  output logic [1:0] keep_charge_mode,
  output logic reset_black,
  output logic continuous_precharge,
  output logic amps_disconnected,
  output logic reset_all
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [11:0] seq_reg, seq_next;
  logic [10:0] npix_reg, npix_next;
  logic [11:0] int_reg, int_next;
  logic [6:0] xstart_reg, xstart_next;
  logic [7:0] ystart_reg, ystart_next;
  logic [7:0] core_reg, core_next;

  // Saturating clamp keeps start positions inside the legal coordinate set
  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] mx);
    clamp8 = (v > mx) ? mx : v;
  endfunction

  // Register writes
  always_comb
  begin
    seq_next = seq_reg;
    npix_next = npix_reg;
    int_next = int_reg;
    xstart_next = xstart_reg;
    ystart_next = ystart_reg;
    core_next = core_reg;
    if (reg_wr)
    begin
      case (reg_addr)
        `PRS_OFF_SEQ: seq_next = reg_wdata; // [RULE_10]
        `PRS_OFF_NPIX: npix_next = (reg_wdata[10:0] > `PRS_NPIX_MAX) ?
          `PRS_NPIX_MAX : reg_wdata[10:0]; // [RULE_19]
        `PRS_OFF_INT: int_next = reg_wdata;
        `PRS_OFF_WIN: xstart_next = 7'(clamp8({1'b0, reg_wdata[6:0]},
          {1'b0, `PRS_XSTART_MAX})); // [RULE_03]
        `PRS_OFF_YSTART: ystart_next = clamp8(reg_wdata[7:0],
          `PRS_YSTART_MAX); // [RULE_03]
        `PRS_OFF_CORE: core_next = reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_reg <= `PRS_SEQ_RST; // [RULE_18]
      npix_reg <= `PRS_NPIX_RST;
      int_reg <= `PRS_INT_RST;
      xstart_reg <= 7'h00;
      ystart_reg <= 8'h00;
      core_reg <= 8'h00;
    end
    else
    begin
      seq_reg <= seq_next;
      npix_reg <= npix_next;
      int_reg <= int_next;
      xstart_reg <= xstart_next;
      ystart_reg <= ystart_next;
      core_reg <= core_next;
    end
  end

  // Readback; unmapped offsets read zero
  always_comb
  begin
    case (reg_addr)
      `PRS_OFF_SEQ: reg_rdata = seq_reg;
      `PRS_OFF_NPIX: reg_rdata = {1'b0, npix_reg};
      `PRS_OFF_INT: reg_rdata = int_reg;
      `PRS_OFF_WIN: reg_rdata = {5'h00, xstart_reg};
      `PRS_OFF_YSTART: reg_rdata = {4'h0, ystart_reg};
      `PRS_OFF_CORE: reg_rdata = {4'h0, core_reg};
      default: reg_rdata = 12'h000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  logic keep_mode;
  logic [1:0] variant;
  logic [3:0] xstep, ystep;
  assign keep_mode = seq_reg[`PRS_BIT_KEEP];
  assign variant = seq_reg[`PRS_BIT_VAR_HI:`PRS_BIT_VAR_LO];

  prs_step_decode u_xstep
  (
    .code(core_reg[`PRS_CORE_XSUB_HI:`PRS_CORE_XSUB_LO]), // [RULE_23]
    .step(xstep)
  );
  prs_step_decode u_ystep
  (
    .code(core_reg[`PRS_CORE_YSUB_HI:`PRS_CORE_YSUB_LO]), // [RULE_23]
    .step(ystep)
  );

  // Static control outputs, straight from the sequencer register
  assign double_sample = !keep_mode; // [RULE_11]
  assign keep_charge_mode = keep_mode ? variant : 2'b00; // [RULE_12]
  assign reset_black = seq_reg[`PRS_BIT_RST_BLACK]; // [RULE_13]
  assign continuous_precharge = seq_reg[`PRS_BIT_PRECHARGE]; // [RULE_14]
  assign amps_disconnected = seq_reg[`PRS_BIT_DARK]; // [RULE_16]
  assign reset_all = seq_reg[`PRS_BIT_RST_ALL]; // [RULE_17]
  // Reset frames are the even variant codes
  assign keep_charge_reset_frame = keep_mode &&
    (prs_variant_t'(variant) == PRS_KEEP_RST1 ||
     prs_variant_t'(variant) == PRS_KEEP_RST2); // [RULE_22]
  assign both_side_drive = seq_reg[`PRS_BIT_BOTH_SIDE] || keep_mode; // [RULE_06]

  ////////////////////////////////////////////////////////////////////////
  // Column clock divider: granularity 0..3 gives enable every 1..4 cycles
  logic [1:0] gran_cnt_reg, gran_cnt_next;
  logic [1:0] gran;
  assign gran = seq_reg[`PRS_BIT_GRAN_HI:`PRS_BIT_GRAN_LO]; // [RULE_15]
  assign col_clock_en = (gran_cnt_reg == gran);

  always_comb
  begin
    gran_cnt_next = col_clock_en ? 2'b00 : gran_cnt_reg + 2'b01; // [RULE_15]
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gran_cnt_reg <= 2'b00;
    else
      gran_cnt_reg <= gran_cnt_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Row pointers and line sequence
  prs_state_t state_reg, state_next;
  logic [ROW_W-1:0] rd_reg, rd_next, rs_reg, rs_next;
  logic rs_active_reg, rs_active_next;
  logic [ROW_W-1:0] rows_done_reg, rows_done_next;
  logic [8:0] blank_reg, blank_next;
  logic [11:0] col_reg, col_next;
  logic [10:0] pair_cnt_reg, pair_cnt_next;
  logic [ROW_W-1:0] row_base;
  logic [11:0] col_base;

  // Start coordinates: rows singly, columns in 12-column units, half of the 24-wide block
  assign row_base = ROW_W'(ystart_reg); // [RULE_04]
  assign col_base = 12'(xstart_reg) * 12'(`PRS_BLOCK_W / 2); // [RULE_03]

  // Row clock advances the read pointer, and the reset pointer once active; frame start reloads both.
  // Reset pointer trails by int_reg rows; its select is masked off
  // in keep-charge read frames so pixels are reset only once.
  always_comb
  begin
    state_next = state_reg;
    rd_next = rd_reg;
    rs_next = rs_reg;
    rs_active_next = rs_active_reg;
    rows_done_next = rows_done_reg;
    blank_next = blank_reg;
    col_next = col_reg;
    pair_cnt_next = pair_cnt_reg;
    if (frame_start)
    begin
      rd_next = row_base; // [RULE_08]
      rs_next = row_base;
      rows_done_next = '0;
      rs_active_next = 1'b0;
      state_next = PRS_IDLE;
    end
    else if (row_clock)
    begin
      rd_next = rd_reg + ROW_W'(ystep); // [RULE_05]
      rows_done_next = rows_done_reg + 1'b1;
      if (rows_done_reg + 1'b1 >= int_reg[ROW_W-1:0])
        rs_active_next = 1'b1; // [RULE_21]
      if (rs_active_reg)
        rs_next = rs_reg + ROW_W'(ystep); // [RULE_05]
      blank_next = 9'(BLANK_CYC - 1);
      col_next = col_base;
      pair_cnt_next = '0;
      state_next = PRS_BLANK; // [RULE_09]
    end
    else
    begin
      case (state_reg)
        PRS_IDLE: ;
        PRS_BLANK:
          if (blank_reg == 9'h000)
            state_next = PRS_LINE;
          else
            blank_next = blank_reg - 9'h001;
        PRS_LINE:
          if (col_clock_en)
          begin
            if (pair_cnt_reg >= npix_reg - 11'h001)
              state_next = PRS_IDLE;
            else
            begin
              col_next = col_reg + 12'(xstep); // [RULE_01]
              pair_cnt_next = pair_cnt_reg + 11'h001;
            end
          end
        default: state_next = PRS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= PRS_IDLE;
      rd_reg <= '0;
      rs_reg <= '0;
      rs_active_reg <= 1'b0;
      rows_done_reg <= '0;
      blank_reg <= 9'h000;
      col_reg <= 12'h000;
      pair_cnt_reg <= 11'h000;
    end
    else
    begin
      state_reg <= state_next;
      rd_reg <= rd_next;
      rs_reg <= rs_next;
      rs_active_reg <= rs_active_next;
      rows_done_reg <= rows_done_next;
      blank_reg <= blank_next;
      col_reg <= col_next;
      pair_cnt_reg <= pair_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign read_row = rd_reg;
  assign reset_row = rs_reg;
  assign read_row_sel = (state_reg != PRS_IDLE);
  // Reset select held off in keep-charge read frames while the pointer still advances: single reset per pixel
  assign reset_row_sel = rs_active_reg &&
    !(keep_mode && !keep_charge_reset_frame); // [RULE_20]
  assign blanking = (state_reg == PRS_BLANK);
  // Even and odd column of a pair leave together on their buses
  assign col_even = col_reg; // [RULE_02] [RULE_04]
  assign col_odd = col_reg + 12'h001; // [RULE_02]
  assign col_pair_valid = (state_reg == PRS_LINE) && col_clock_en;

endmodule

// ### common/prs_map.svh
// Register offsets, field positions, reset values and limits of the readout sequencer
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH
`define PRS_ADDR_W 4
`define PRS_OFF_SEQ 4'h0
`define PRS_OFF_NPIX 4'h1
`define PRS_OFF_WIN 4'h5
`define PRS_OFF_YSTART 4'h6
`define PRS_OFF_CORE 4'h7
`define PRS_OFF_INT 4'h3
`define PRS_SEQ_RST 12'h0100
`define PRS_NPIX_RST 11'h0100
`define PRS_NPIX_MAX 11'h0457
`define PRS_XSTART_MAX 7'h62
`define PRS_YSTART_MAX 8'h89
`define PRS_INT_RST 12'h0001
`define PRS_BIT_KEEP 0
`define PRS_BIT_VAR_LO 1
`define PRS_BIT_VAR_HI 2
`define PRS_BIT_RST_BLACK 3
`define PRS_BIT_BOTH_SIDE 4
`define PRS_BIT_PRECHARGE 7
`define PRS_BIT_GRAN_LO 8
`define PRS_BIT_GRAN_HI 9
`define PRS_BIT_DARK 10
`define PRS_BIT_RST_ALL 11
`define PRS_CORE_XSUB_LO 2
`define PRS_CORE_XSUB_HI 4
`define PRS_CORE_YSUB_LO 5
`define PRS_CORE_YSUB_HI 7
`define PRS_BLOCK_W 24
`define PRS_READ_W 2
`endif

// ### common/prs_pkg.sv
// Types shared by the readout sequencer
package prs_pkg;
  typedef enum logic [1:0] {
    PRS_KEEP_RST1,
    PRS_KEEP_RD1,
    PRS_KEEP_RST2,
    PRS_KEEP_RD2
  } prs_variant_t;
  typedef enum logic [1:0] {
    PRS_IDLE,
    PRS_BLANK,
    PRS_LINE
  } prs_state_t;
endpackage

// ### verilog/prs_step_decode.sv
// Sub-sampling step decoder: pixels advanced per read pair
`include "prs_map.svh"
module prs_step_decode
  import prs_pkg::*;
(
  input wire logic [2:0] code,
  output logic [3:0] step
);
  // Codes with top bit set all collapse to the widest step
  always_comb
  begin
    case (code)
      3'b000: step = 4'h2; // [RULE_01]
      3'b001: step = 4'h4;
      3'b010: step = 4'h6;
      3'b011: step = 4'h8;
      default: step = 4'hC; // [RULE_01]
    endcase
  end
endmodule

// ### tb/prs_seq_monitor.sv
// Port-level checker of the readout sequencer
`include "prs_map.svh"
module prs_seq_monitor
  import prs_pkg::*;
#(
  parameter int ROW_W = 12
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`PRS_ADDR_W-1:0] reg_addr,
  input wire logic [11:0] reg_rdata,
  input wire logic frame_start,
  input wire logic row_clock,
  input wire logic [ROW_W-1:0] read_row,
  input wire logic both_side_drive,
  input wire logic [11:0] col_even,
  input wire logic [11:0] col_odd,
  input wire logic col_pair_valid,
  input wire logic blanking,
  input wire logic double_sample,
  input wire logic keep_charge_reset_frame,
  input wire logic [1:0] keep_charge_mode,
  input wire logic reset_black,
  input wire logic continuous_precharge,
  input wire logic amps_disconnected,
  input wire logic reset_all
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Mode levels are judged only while readback shows the sequencer word
  sequence s_seq_view;
    reg_addr == `PRS_OFF_SEQ;
  endsequence
  sequence s_row_tick;
    row_clock && !frame_start;
  endsequence
  sequence s_blank_run;
    blanking [*8];
  endsequence
  property p_mode_sel;
    s_seq_view |-> double_sample == !reg_rdata[0];
  endproperty
  property p_both_side;
    s_seq_view |-> both_side_drive == (reg_rdata[4] | reg_rdata[0]);
  endproperty
  property p_variant;
    s_seq_view |-> keep_charge_mode == (reg_rdata[0] ? reg_rdata[2:1] : 2'b00);
  endproperty
  property p_reset_frame;
    s_seq_view |-> keep_charge_reset_frame == (reg_rdata[0] & ~reg_rdata[1]);
  endproperty
  property p_flags;
    s_seq_view |-> {continuous_precharge, reset_black} == {reg_rdata[7], reg_rdata[3]};
  endproperty
  property p_flags_hi;
    s_seq_view |-> {reset_all, amps_disconnected} == reg_rdata[11:10];
  endproperty
  property p_pair;
    col_pair_valid |-> col_odd == col_even + 12'h0001;
  endproperty
  property p_row_blank;
    s_row_tick |=> s_blank_run;
  endproperty
  property p_row_move;
    s_row_tick |=> read_row != $past(read_row);
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("readout mode level wrong");
  a_both_side: assert property (p_both_side) else $error("both side drive wrong");
  a_variant: assert property (p_variant) else $error("variant level wrong");
  a_reset_frame: assert property (p_reset_frame) else $error("reset frame wrong");
  a_flags: assert property (p_flags) else $error("control flags wrong");
  a_flags_hi: assert property (p_flags_hi) else $error("flags wrong");
  a_pair: assert property (p_pair) else $error("column pair not adjacent");
  a_row_blank: assert property (p_row_blank) else $error("blanking too short");
  a_row_move: assert property (p_row_move) else $error("read row did not move");
endmodule

// ### tb/prs_ctrl_model.sv
// Camera controller model: frame and row pulses
module prs_ctrl_model
(
  input wire logic clk,
  output logic frame_start,
  output logic row_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    frame_start = 1'b0;
    row_clock = 1'b0;
  end
  // One-cycle pulse launched on the falling edge, steady at the rising edge
  task automatic pulse(input bit frame);
    @(negedge clk);
    if (frame)
      frame_start = 1'b1;
    else
      row_clock = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    row_clock = 1'b0;
  endtask
endmodule

// ### tb/pixel_readout_sequencer_bench.sv
// Self-checking bench of the readout sequencer
`include "prs_map.svh"
module pixel_readout_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [11:0] reg_wdata = 12'h0000;
  logic [11:0] reg_rdata, read_row, reset_row, col_even, col_odd, d, pe, r;
  logic frame_start, row_clock, read_row_sel, reset_row_sel, both_side_drive;
  logic col_pair_valid, col_clock_en, blanking, double_sample, keep_charge_reset_frame;
  logic reset_black, continuous_precharge, amps_disconnected, reset_all;
  logic [1:0] keep_charge_mode, g;
  logic [10:0] n;
  logic [6:0] x;
  int error_cnt = 0;
  int checks = 0;
  int k, pw, seed;
  prs_sequencer #(.BLANK_CYC(8)) uut (.clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .frame_start, .row_clock, .read_row, .reset_row, .read_row_sel,
    .reset_row_sel, .both_side_drive, .col_even, .col_odd, .col_pair_valid,
    .col_clock_en, .blanking, .double_sample, .keep_charge_reset_frame,
    .keep_charge_mode, .reset_black, .continuous_precharge, .amps_disconnected,
    .reset_all);
  prs_ctrl_model ctl (.clk, .frame_start, .row_clock);
  // Pixel clock, 25 ns period
  always #12.5 clk = ~clk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] v);
    checks++;
    if (v !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, v);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Write, then one idle cycle so the strobe is never raised twice in a step
  task automatic wr(input logic [3:0] a, input logic [11:0] v);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [11:0] e, input string nm);
    reg_addr = a;
    #1 chk(nm, e, reg_rdata);
  endtask
  function automatic int stp(input logic [2:0] c);
    return c[2] ? 12 : 2 * (int'(c) + 1);
  endfunction
  // Reset pointer moves only once the row count has passed the integration setting
  function automatic int rs_exp(input int t, input int it, input int s);
    return (t > it) ? s * (t - it) : 0;
  endfunction
  ////////////////////////////////////////
  initial
  begin
    seed = $urandom(32'h0000_cc77);
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    rd(`PRS_OFF_SEQ, 12'h0100, "seq_rst");
    rd(`PRS_OFF_NPIX, 12'h0100, "npix_rst");
    wr(4'hd, 12'hfff);
    rd(4'hd, 12'h0000, "unmapped");
    wr(`PRS_OFF_NPIX, 12'h07ff);
    rd(`PRS_OFF_NPIX, 12'h0457, "npix_max");
    wr(`PRS_OFF_WIN, 12'h0fff);
    rd(`PRS_OFF_WIN, 12'h0062, "xstart_max");
    wr(`PRS_OFF_YSTART, 12'h0fff);
    rd(`PRS_OFF_YSTART, 12'h0089, "ystart_max");
    // Random sequencer words; low bits walk every mode and variant code
    for (int i = 0; i < 24; i++)
    begin
      d = 12'($urandom);
      d[2:0] = 3'(i);
      wr(`PRS_OFF_SEQ, d);
      rd(`PRS_OFF_SEQ, d, "seq");
      chk("dsamp", !d[0], double_sample);
      chk("both", d[4] | d[0], both_side_drive);
      chk("kmode", d[0] ? d[2:1] : 2'b00, keep_charge_mode);
      chk("kreset", d[0] & ~d[1], keep_charge_reset_frame);
      chk("flags_lo", {d[7], d[3]}, {continuous_precharge, reset_black});
      chk("flags_hi", d[11:10], {reset_all, amps_disconnected});
    end
    // One short line per sub-sampling code, settings loaded between frames
    wr(`PRS_OFF_YSTART, 12'h0000);
    for (int c = 0; c < 8; c++)
    begin
      g = 2'(c);
      n = 11'(2 + $urandom % 4);
      x = 7'($urandom % 99);
      wr(`PRS_OFF_SEQ, {2'b00, g, 8'h00});
      wr(`PRS_OFF_NPIX, 12'(n));
      wr(`PRS_OFF_WIN, 12'(x));
      rd(`PRS_OFF_WIN, 12'(x), "xstart");
      wr(`PRS_OFF_CORE, {4'h0, 3'(c), 3'(c), 2'b00});
      ctl.pulse(1'b1);
      r = read_row;
      ctl.pulse(1'b0);
      chk("row", r + 12'(stp(3'(c))), read_row);
      k = 0;
      for (int w = 0; w < 100; w++)
      begin
        @(negedge clk);
        if (col_pair_valid)
        begin
          if (k > 0)
          begin
            chk("step", 12'(stp(3'(c))), col_even - pe);
            chk("gap", 12'(g) + 12'h0001, 12'(w - pw));
          end
          else
            chk("start", 12'(x) * 12'h000c, col_even);
          pe = col_even;
          pw = w;
          k++;
        end
      end
      chk("pairs", 12'(n), 12'(k));
    end
    // Reset pointer trails by the integration rows; its select stays off in keep-charge read frames
    wr(`PRS_OFF_CORE, 12'h0000);
    wr(`PRS_OFF_INT, 12'h0002);
    for (int m = 0; m < 2; m++)
    begin
      wr(`PRS_OFF_SEQ, m ? 12'h0103 : 12'h0100);
      ctl.pulse(1'b1);
      chk("rd_sel_idle", 12'h0000, 12'(read_row_sel));
      for (int t = 1; t < 5; t++)
      begin
        ctl.pulse(1'b0);
        chk("rd_sel", 12'h0001, 12'(read_row_sel));
        chk("rd_row", 12'(2 * t), read_row);
        chk("rs_row", 12'(rs_exp(t, 2, 2)), reset_row);
        chk("rs_sel", 12'(t >= 2 && m == 0), 12'(reset_row_sel));
      end
      // Let the blanking run finish before the next frame start
      repeat (10) @(negedge clk);
    end
    // Mid-run reset brings registers and pointers back to their defaults
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    rd(`PRS_OFF_SEQ, 12'h0100, "seq_rst2");
    rd(`PRS_OFF_NPIX, 12'h0100, "npix_rst2");
    chk("row_rst", 12'h0000, read_row);
    chk("rs_rst", 12'h0000, reset_row);
    stop_test();
  end
endmodule
bind prs_sequencer prs_seq_monitor #(.ROW_W(ROW_W)) mon (.clk, .rst_n, .reg_addr,
  .reg_rdata, .frame_start, .row_clock, .read_row, .both_side_drive, .col_even,
  .col_odd, .col_pair_valid, .blanking, .double_sample, .keep_charge_reset_frame,
  .keep_charge_mode, .reset_black, .continuous_precharge, .amps_disconnected,
  .reset_all);
